/* File: flash_host_ctrl.sv */
// Host-side controller for a byte-wide parallel flash: reads, byte program,
// sector and chip erase with unlock sequences, and toggle polling for completion.
// Assumes the pins connect straight to the flash; dq pins are split in/out/enable.
`timescale 1ns/1ns
`default_nettype none
module flash_host_ctrl
    import flash_host_pkg::*;
#(
    parameter int unsigned SECT_TMO_CYC = SECT_CYC,
    parameter int unsigned CHIP_TMO_CYC = CHIP_CYC,
    parameter bit          CE_CTRL      = 1'b0
) (
    input  wire logic                      mclk_i,
    input  wire logic                      sys_rst_i,
    input  wire logic                      cmd_valid_i,
    input  wire flash_host_pkg::cmd_type   cmd_i,
    output logic                           cmd_ready_o,
    output logic                           rsp_valid_o,
    output flash_host_pkg::rsp_type        rsp_o,
    output logic [flash_host_pkg::ADDR_W-1:0] flash_addr_o,
    output logic                           flash_ce_n_o,
    output logic                           flash_oe_n_o,
    output logic                           flash_we_n_o,
    output logic [flash_host_pkg::DATA_W-1:0] flash_dq_o,
    output logic                           flash_dq_oe_o,
    input  wire logic [flash_host_pkg::DATA_W-1:0] flash_dq_i
);
    import flash_host_pkg::*;

    typedef enum logic [2:0] {
        M_IDLE    = 3'b000,
        M_CHECK   = 3'b001,
        M_SEQ     = 3'b011,
        M_POLL_A  = 3'b010,
        M_POLL_B  = 3'b110,
        M_RESP    = 3'b111,
        M_RESTORE = 3'b101
    } main_state_type;

    main_state_type     state_r, state_nxt;
    cmd_type            cmd_r, cmd_nxt;
    logic [2:0]         step_r, step_nxt;
    logic               issued_r, issued_nxt;
    logic [DATA_W-1:0]  prev_r, prev_nxt;
    logic [31:0]        tmo_r, tmo_nxt;
    rsp_type            rsp_r, rsp_nxt;
    logic               rsp_valid_r, rsp_valid_nxt;

    logic               bus_start, bus_write, bus_ready, bus_done;
    word_type           bus_word;
    logic [DATA_W-1:0]  bus_rd;
    pins_type           pins;

    ////////////////////////////////////////////////////////////////////////
    // Bus word (unlock, command code or program data) for a given step of a command
    function automatic word_type seq_word(input cmd_type c, input logic [2:0] s);
        word_type w;
        w = '{addr: ADDR_UNLOCK_A, data: CODE_UNLOCK_A};
        unique case (s)
            3'h0: begin
                if (c.op == OP_READ_RESET) w = '{addr: c.addr, data: CODE_READ};
            end
            3'h1: w = '{addr: ADDR_UNLOCK_B, data: CODE_UNLOCK_B};
            3'h2: w.data = (c.op == OP_PROGRAM) ? CODE_PROGRAM : CODE_ERASE;
            3'h3: begin
                if (c.op == OP_PROGRAM) w = '{addr: c.addr, data: c.data};
            end
            3'h4: w = '{addr: ADDR_UNLOCK_B, data: CODE_UNLOCK_B};
            default: begin
                if (c.op == OP_SECTOR_ERASE) w = '{addr: c.addr, data: CODE_SECTOR};
                else                         w.data = CODE_CHIP;
            end
        endcase
        return w;
    endfunction : seq_word

    function automatic logic [2:0] seq_len(input op_type op);
        unique case (op)
            OP_PROGRAM:                    return PROGRAM_LEN;
            OP_SECTOR_ERASE, OP_CHIP_ERASE: return ERASE_LEN;
            default:                       return SINGLE_LEN;
        endcase
    endfunction : seq_len

    function automatic logic [31:0] tmo_limit(input op_type op);
        unique case (op)
            OP_SECTOR_ERASE: return 32'(SECT_TMO_CYC);
            OP_CHIP_ERASE:   return 32'(CHIP_TMO_CYC);
            default:         return 32'(PROG_CYC);
        endcase
    endfunction : tmo_limit

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_nxt     = state_r;
        cmd_nxt       = cmd_r;
        step_nxt      = step_r;
        issued_nxt    = issued_r;
        prev_nxt      = prev_r;
        tmo_nxt       = tmo_r;
        rsp_nxt       = rsp_r;
        rsp_valid_nxt = 1'b0;
        bus_start     = 1'b0;
        bus_write     = 1'b0;
        bus_word      = '{addr: cmd_r.addr, data: cmd_r.data};

        if (state_r == M_POLL_A || state_r == M_POLL_B) tmo_nxt = tmo_r + 32'h1;
        if (bus_done) issued_nxt = 1'b0;

        unique case (state_r)
            M_IDLE: begin
                if (cmd_valid_i) begin
                    cmd_nxt  = cmd_i;
                    step_nxt = '0;
                    if (cmd_i.op == OP_READ || cmd_i.op == OP_PROGRAM) state_nxt = M_CHECK;
                    else                                                state_nxt = M_SEQ;
                end
            end
            M_CHECK: begin
                bus_start = bus_ready && !issued_r;
                if (bus_start) issued_nxt = 1'b1;
                if (bus_done) begin
                    rsp_nxt = '{data: bus_rd, err: 1'b0};
                    if (cmd_r.op == OP_READ) begin
                        state_nxt = M_RESP;
                    end else if ((bus_rd & cmd_r.data) != cmd_r.data) begin
                        rsp_nxt.err = 1'b1;
                        state_nxt   = M_RESP;
                    end else begin
                        state_nxt = M_SEQ;
                    end
                end
            end
            M_SEQ: begin
                bus_write = 1'b1;
                bus_word  = seq_word(cmd_r, step_r);
                bus_start = bus_ready && !issued_r;
                if (bus_start) issued_nxt = 1'b1;
                if (bus_done) begin
                    step_nxt = step_r + 3'h1;
                    if (step_r == seq_len(cmd_r.op) - 3'h1) begin
                        tmo_nxt = '0;
                        rsp_nxt = '{data: cmd_r.data, err: 1'b0};
                        state_nxt = (cmd_r.op == OP_READ_RESET) ? M_RESP : M_POLL_A;
                    end
                end
            end
            M_POLL_A, M_POLL_B: begin
                bus_start = bus_ready && !issued_r;
                if (bus_start) issued_nxt = 1'b1;
                if (bus_done) begin
                    prev_nxt  = bus_rd;
                    state_nxt = M_POLL_B;
                    if (state_r == M_POLL_B &&
                        bus_rd[ACTIVITY_TOGGLE_BIT] == prev_r[ACTIVITY_TOGGLE_BIT]) begin
                        rsp_nxt.data = bus_rd;
                        rsp_nxt.err  = (cmd_r.op == OP_PROGRAM) ? (bus_rd != cmd_r.data)
                                     : !bus_rd[COMPLETION_POLL_BIT];
                        state_nxt    = M_RESP;
                    end else if (tmo_r >= tmo_limit(cmd_r.op)) begin
                        state_nxt = M_RESTORE;
                    end
                end
            end
            M_RESTORE: begin
                bus_write = 1'b1;
                bus_word  = '{addr: ADDR_UNLOCK_A, data: CODE_NOP};
                bus_start = bus_ready && !issued_r;
                if (bus_start) issued_nxt = 1'b1;
                if (bus_done) begin
                    rsp_nxt   = '{data: prev_r, err: 1'b1};
                    state_nxt = M_RESP;
                end
            end
            M_RESP: begin
                rsp_valid_nxt = 1'b1;
                state_nxt     = M_IDLE;
            end
            default: state_nxt = M_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            state_r     <= M_IDLE;
            cmd_r       <= '0;
            step_r      <= '0;
            issued_r    <= 1'b0;
            prev_r      <= '0;
            tmo_r       <= '0;
            rsp_r       <= '0;
            rsp_valid_r <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            cmd_r       <= cmd_nxt;
            step_r      <= step_nxt;
            issued_r    <= issued_nxt;
            prev_r      <= prev_nxt;
            tmo_r       <= tmo_nxt;
            rsp_r       <= rsp_nxt;
            rsp_valid_r <= rsp_valid_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    flash_bus_cycle #(
        .CE_CTRL (CE_CTRL)
    ) u_cycle (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .start_i   (bus_start),
        .write_i   (bus_write),
        .word_i    (bus_word),
        .dq_i      (flash_dq_i),
        .pins_o    (pins),
        .rd_data_o (bus_rd),
        .ready_o   (bus_ready),
        .done_o    (bus_done)
    );

    // New commands wait until the previous operation has fully finished
    assign cmd_ready_o   = (state_r == M_IDLE);
    assign rsp_valid_o   = rsp_valid_r;
    assign rsp_o         = rsp_r;
    assign flash_addr_o  = pins.addr;
    assign flash_ce_n_o  = pins.ce_n;
    assign flash_oe_n_o  = pins.oe_n;
    assign flash_we_n_o  = pins.we_n;
    assign flash_dq_o    = pins.dq_out;
    assign flash_dq_oe_o = pins.dq_oe;

endmodule : flash_host_ctrl
`default_nettype wire

/* File: flash_host_pkg.sv */
// Constants, types and timing for the parallel flash host controller.
// Assumes a single 10 MHz clock; the counts below are derived from it, except CHIP_CYC, which has 10000 cycles per ms fixed.
`default_nettype none
package flash_host_pkg;

    localparam int unsigned ADDR_W          = 16;
    localparam int unsigned DATA_W          = 8;
    localparam int unsigned CLK_PERIOD_NS   = 100;
    localparam int unsigned SYNC_STAGES     = 2;

    // Strobe and access times in ns
    localparam int unsigned T_WP_NS         = 45;
    localparam int unsigned T_WPH_NS        = 38;
    localparam int unsigned T_ACC_NS        = 90;
    localparam int unsigned T_DF_NS         = 30;
    // Self-timed operation limits
    localparam int unsigned T_PROG_US       = 20;
    localparam int unsigned T_SECT_ERASE_MS = 10;
    localparam int unsigned T_CHIP_ERASE_MS = 500;
    localparam int unsigned CHIP_MARGIN     = 2;

    function automatic int unsigned min_cyc(input int unsigned ns);
        int unsigned c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c == 0) ? 1 : c;
    endfunction : min_cyc

    localparam int unsigned WP_CYC    = min_cyc(T_WP_NS);
    localparam int unsigned ACC_CYC   = min_cyc(T_ACC_NS) + SYNC_STAGES;
    localparam int unsigned REC_CYC   = min_cyc((T_WPH_NS > T_DF_NS) ? T_WPH_NS : T_DF_NS);
    localparam int unsigned PROG_CYC  = T_PROG_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned SECT_CYC  = T_SECT_ERASE_MS * 1000 * 1000 / CLK_PERIOD_NS;
    localparam int unsigned CHIP_CYC  = T_CHIP_ERASE_MS * CHIP_MARGIN * 10000;

    // Command addresses and codes
    localparam logic [ADDR_W-1:0] ADDR_UNLOCK_A = 16'h5555;
    localparam logic [ADDR_W-1:0] ADDR_UNLOCK_B = 16'h2aaa;
    localparam logic [DATA_W-1:0] CODE_UNLOCK_A = 8'haa;
    localparam logic [DATA_W-1:0] CODE_UNLOCK_B = 8'h55;
    localparam logic [DATA_W-1:0] CODE_PROGRAM  = 8'ha0;
    localparam logic [DATA_W-1:0] CODE_ERASE    = 8'h80;
    localparam logic [DATA_W-1:0] CODE_SECTOR   = 8'h30;
    localparam logic [DATA_W-1:0] CODE_CHIP     = 8'h10;
    localparam logic [DATA_W-1:0] CODE_READ     = 8'hf0;
    localparam logic [DATA_W-1:0] CODE_NOP      = 8'hff;

    localparam int unsigned COMPLETION_POLL_BIT = 7;
    localparam int unsigned ACTIVITY_TOGGLE_BIT = 6;
    localparam logic [2:0]  PROGRAM_LEN = 3'h4;
    localparam logic [2:0]  ERASE_LEN   = 3'h6;
    localparam logic [2:0]  SINGLE_LEN  = 3'h1;

    typedef enum logic [2:0] {
        OP_READ         = 3'h0,
        OP_PROGRAM      = 3'h1,
        OP_SECTOR_ERASE = 3'h2,
        OP_CHIP_ERASE   = 3'h3,
        OP_READ_RESET   = 3'h4
    } op_type;

    typedef struct packed {
        op_type              op;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   data;
    } cmd_type;

    typedef struct packed {
        logic [DATA_W-1:0]   data;
        logic                err;
    } rsp_type;

    typedef struct packed {
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   data;
    } word_type;

    typedef struct packed {
        logic [ADDR_W-1:0]   addr;
        logic                ce_n;
        logic                oe_n;
        logic                we_n;
        logic [DATA_W-1:0]   dq_out;
        logic                dq_oe;
    } pins_type;

    localparam pins_type PINS_IDLE = '{addr: '0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                                      dq_out: '0, dq_oe: 1'b0};

endpackage : flash_host_pkg
`default_nettype wire

/* File: flash_bus_cycle.sv */
// One asynchronous bus cycle (read or write) on the flash pins.
// Assumes dq_i is a pin from outside the clock domain; it is synchronised here.
`timescale 1ns/1ns
`default_nettype none
module flash_bus_cycle
    import flash_host_pkg::*;
#(
    parameter bit CE_CTRL = 1'b0
) (
    input  wire logic                  mclk_i,
    input  wire logic                  sys_rst_i,
    input  wire logic                  start_i,
    input  wire logic                  write_i,
    input  wire flash_host_pkg::word_type word_i,
    input  wire logic [flash_host_pkg::DATA_W-1:0] dq_i,
    output var  flash_host_pkg::pins_type pins_o,
    output logic [flash_host_pkg::DATA_W-1:0] rd_data_o,
    output logic                       ready_o,
    output logic                       done_o
);
    import flash_host_pkg::*;

    typedef enum logic [1:0] {
        BC_IDLE = 2'b00, BC_STROBE = 2'b01, BC_HOLD = 2'b11, BC_RECOVER = 2'b10
    } bc_state_type;

    bc_state_type         state_r, state_nxt;
    logic [7:0]           cnt_r, cnt_nxt;
    logic                 wr_r, wr_nxt;
    pins_type             pins_r, pins_nxt;
    logic [DATA_W-1:0]    rd_r, rd_nxt;
    logic [DATA_W-1:0]    dq_meta_r, dq_sync_r;
    logic                 done_nxt, done_r;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk_i) begin
        dq_meta_r <= dq_i;
        dq_sync_r <= dq_meta_r;
    end

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        wr_nxt    = wr_r;
        pins_nxt  = pins_r;
        rd_nxt    = rd_r;
        done_nxt  = 1'b0;
        unique case (state_r)
            BC_IDLE: begin
                if (start_i) begin
                    wr_nxt         = write_i;
                    cnt_nxt        = '0;
                    pins_nxt.addr  = word_i.addr;
                    pins_nxt.ce_n  = 1'b0;
                    pins_nxt.we_n  = ~write_i;
                    pins_nxt.oe_n  = write_i;
                    pins_nxt.dq_out = word_i.data;
                    pins_nxt.dq_oe = write_i;
                    state_nxt      = BC_STROBE;
                end
            end
            BC_STROBE: begin
                cnt_nxt = cnt_r + 8'h01;
                if (cnt_r == 8'((wr_r ? WP_CYC : ACC_CYC) - 1)) begin
                    if (wr_r) begin
                        if (CE_CTRL) pins_nxt.ce_n = 1'b1;
                        else         pins_nxt.we_n = 1'b1;
                    end else begin
                        rd_nxt        = dq_sync_r;
                        pins_nxt.oe_n = 1'b1;
                        pins_nxt.ce_n = 1'b1;
                    end
                    state_nxt = BC_HOLD;
                end
            end
            BC_HOLD: begin
                pins_nxt.ce_n  = 1'b1;
                pins_nxt.we_n  = 1'b1;
                pins_nxt.dq_oe = 1'b0;
                cnt_nxt        = '0;
                state_nxt      = BC_RECOVER;
            end
            BC_RECOVER: begin
                cnt_nxt = cnt_r + 8'h01;
                if (cnt_r == 8'(REC_CYC - 1)) begin
                    done_nxt  = 1'b1;
                    state_nxt = BC_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            state_r <= BC_IDLE;
            cnt_r   <= '0;
            wr_r    <= 1'b0;
            pins_r  <= PINS_IDLE;
            rd_r    <= '0;
            done_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            wr_r    <= wr_nxt;
            pins_r  <= pins_nxt;
            rd_r    <= rd_nxt;
            done_r  <= done_nxt;
        end
    end

    assign pins_o    = pins_r;
    assign rd_data_o = rd_r;
    assign done_o    = done_r;
    assign ready_o   = (state_r == BC_IDLE) && !done_r;

endmodule : flash_bus_cycle
`default_nettype wire

/* File: flash_host_props.sv */
// Checker for the flash host controller: strobe framing and handshake.
// Bound to flash_host_ctrl; sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module flash_host_props
    import flash_host_pkg::*;
#(
    parameter int unsigned SECT_TMO_CYC = 200,
    parameter int unsigned CHIP_TMO_CYC = 200,
    parameter bit          CE_CTRL      = 1'b0
) (
    input wire logic                              mclk_i,
    input wire logic                              sys_rst_i,
    input wire logic                              cmd_valid_i,
    input wire logic                              cmd_ready_o,
    input wire logic                              rsp_valid_o,
    input wire logic [flash_host_pkg::ADDR_W-1:0] flash_addr_o,
    input wire logic                              flash_ce_n_o,
    input wire logic                              flash_oe_n_o,
    input wire logic                              flash_we_n_o,
    input wire logic [flash_host_pkg::DATA_W-1:0] flash_dq_o,
    input wire logic                              flash_dq_oe_o
);
    import flash_host_pkg::*;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    ////////////////////////////////////////////////////////////////////////
    // Second phase of a write: one strobe up, then both up with dq released
    sequence s_wr_tail;
        (CE_CTRL ? (flash_ce_n_o && !flash_we_n_o) : (flash_we_n_o && !flash_ce_n_o))
            && flash_dq_oe_o ##1 (flash_ce_n_o && flash_we_n_o && !flash_dq_oe_o);
    endsequence
    sequence s_rd_hold;
        (!flash_ce_n_o && !flash_oe_n_o && flash_we_n_o) [*3];
    endsequence
    property p_rd_we;
        !flash_ce_n_o && !flash_oe_n_o |-> flash_we_n_o;
    endproperty
    property p_no_fight;
        !flash_oe_n_o |-> !flash_dq_oe_o;
    endproperty
    property p_wr_oe;
        !flash_we_n_o |-> flash_oe_n_o && flash_dq_oe_o;
    endproperty
    // Reset itself is the cause here, so it must not disable the check
    property p_rst;
        disable iff (1'b0) sys_rst_i |=> flash_ce_n_o && flash_oe_n_o && flash_we_n_o
            && !flash_dq_oe_o && !rsp_valid_o;
    endproperty
    property p_rsp_once;
        rsp_valid_o |=> !rsp_valid_o;
    endproperty
    property p_back_ready;
        rsp_valid_o |-> ##[0:1] cmd_ready_o;
    endproperty
    property p_take;
        cmd_valid_i && cmd_ready_o |=> !cmd_ready_o;
    endproperty
    property p_wr_frame;
        $fell(flash_we_n_o) |-> !flash_ce_n_o ##1 s_wr_tail;
    endproperty
    property p_latch;
        ($rose(flash_ce_n_o) || $rose(flash_we_n_o)) && flash_dq_oe_o
            |-> $stable(flash_addr_o) && $stable(flash_dq_o);
    endproperty
    property p_rd_frame;
        $fell(flash_oe_n_o) |-> s_rd_hold ##1 (flash_oe_n_o && flash_ce_n_o);
    endproperty
    a_rd_we: assert property (p_rd_we) else $error("write strobe low in read");
    a_no_fight: assert property (p_no_fight) else $error("dq driven in read");
    a_wr_oe: assert property (p_wr_oe) else $error("write with oe low");
    a_rst: assert property (p_rst) else $error("pins not idle after reset");
    a_rsp_once: assert property (p_rsp_once) else $error("response too long");
    a_back_ready: assert property (p_back_ready) else $error("not ready after rsp");
    a_take: assert property (p_take) else $error("ready while busy");
    a_wr_frame: assert property (p_wr_frame) else $error("bad write frame");
    a_latch: assert property (p_latch) else $error("addr or data moved");
    a_rd_frame: assert property (p_rd_frame) else $error("bad read frame");
endmodule : flash_host_props
bind flash_host_ctrl flash_host_props #(.SECT_TMO_CYC(SECT_TMO_CYC),
    .CHIP_TMO_CYC(CHIP_TMO_CYC), .CE_CTRL(CE_CTRL)) i_props (.mclk_i, .sys_rst_i,
    .cmd_valid_i, .cmd_ready_o, .rsp_valid_o, .flash_addr_o, .flash_ce_n_o,
    .flash_oe_n_o, .flash_we_n_o, .flash_dq_o, .flash_dq_oe_o);
`default_nettype wire

/* File: flash_dev_model.sv */
// Behavioural byte-wide flash: command decode, array and busy status.
// Strobes come straight from the host; clk_i times the busy period and samples read data into held.
`timescale 1ns/1ns
`default_nettype none
module flash_dev_model #(
    parameter int PROG_BUSY  = 30,
    parameter int ERASE_BUSY = 60,
    parameter int SECT_BYTES = 512
) (
    input  wire logic        clk_i,
    input  wire logic        stall_i,
    input  wire logic [15:0] addr_i,
    input  wire logic        ce_n_i,
    input  wire logic        oe_n_i,
    input  wire logic        we_n_i,
    input  wire logic [7:0]  dq_i,
    output logic [7:0]       dq_o
);
    logic [7:0]  mem [0:65535];
    logic [7:0]  last_d, held;
    logic [15:0] wa;
    logic        wr_act, tog, rd;
    int          step, busy;
    initial begin
        foreach (mem[i]) mem[i] = 8'hff;
        step = 0;
        busy = 0;
        wr_act = 1'b0;
        tog = 1'b0;
        held = 8'h00;
        last_d = 8'h00;
    end
    task automatic erase(input int lo);
        for (int i = lo; i < lo + SECT_BYTES; i++) mem[i] = 8'hff;
    endtask : erase
    task automatic take(input logic [15:0] a, input logic [7:0] d);
        if (busy > 0) return;
        if (step != 3 && d == 8'hf0) step = 0;
        else case (step)
            0, 4: step = (a == 16'h5555 && d == 8'haa) ? step + 1 : 0;
            1, 5: step = (a == 16'h2aaa && d == 8'h55) ? step + 1 : 0;
            2: step = (a != 16'h5555) ? 0 : (d == 8'ha0) ? 3 : (d == 8'h80) ? 4 : 0;
            3: begin
                mem[a] = mem[a] & d;
                last_d = d;
                busy = PROG_BUSY;
                step = 0;
            end
            default: begin
                // chip erase: zero fill, then sector by sector
                last_d = 8'hff;
                if (d == 8'h30) begin
                    erase(int'(a) / SECT_BYTES * SECT_BYTES);
                    busy = ERASE_BUSY;
                end else if (d == 8'h10 && a == 16'h5555) begin
                    foreach (mem[i]) mem[i] = 8'h00;
                    for (int s = 0; s < 65536; s += SECT_BYTES) erase(s);
                    busy = 2 * ERASE_BUSY;
                end
                step = 0;
            end
        endcase
    endtask : take
    always @(negedge ce_n_i or negedge we_n_i) begin
        if (!ce_n_i && !we_n_i && oe_n_i) begin
            wa = addr_i;
            wr_act = 1'b1;
        end
    end
    always @(posedge ce_n_i or posedge we_n_i) begin
        if (wr_act) begin
            wr_act = 1'b0;
            take(wa, dq_i);
        end
    end
    // Stall holds the device busy so the host time-out is reached
    always @(posedge clk_i) begin
        if (busy > 0 && !stall_i) busy = busy - 1;
        if (rd) held <= dq_o;
    end
    assign rd = !ce_n_i && !oe_n_i && we_n_i;
    always @(posedge rd) begin
        if (busy > 0) tog = ~tog;
    end
    // released bus shows inverse of last value
    assign dq_o = !rd ? ~held : (busy > 0) ? {~last_d[7], tog, 6'h00} : mem[addr_i];
endmodule : flash_dev_model
`default_nettype wire

/* File: flash_host_ctrl_tb.sv */
// Self-checking bench for flash_host_ctrl against a behavioural flash.
// Uses the 10 MHz clock and shortened erase time-outs set below.
`timescale 1ns/1ns
`default_nettype none
module flash_host_ctrl_tb;
    import flash_host_pkg::*;
    typedef struct packed {
        logic [7:0] d;
        logic       e;
        logic       c;
    } exp_type;
    logic        mclk_i, sys_rst_i, cmd_valid_i, cmd_ready_o, rsp_valid_o, stall;
    logic        flash_ce_n_o, flash_oe_n_o, flash_we_n_o, flash_dq_oe_o;
    logic [15:0] flash_addr_o;
    logic [7:0]  flash_dq_o, flash_dq_i, dev_dq;
    logic [7:0]  sh [0:65535];
    cmd_type     cmd_i;
    rsp_type     rsp_o;
    exp_type     exp_q [$];
    int          error_cnt, checked, rsp_cnt, seed, tno;
    flash_host_ctrl #(.SECT_TMO_CYC(400), .CHIP_TMO_CYC(400), .CE_CTRL(1'b0)) i_dut (
        .mclk_i, .sys_rst_i, .cmd_valid_i, .cmd_i, .cmd_ready_o, .rsp_valid_o, .rsp_o,
        .flash_addr_o, .flash_ce_n_o, .flash_oe_n_o, .flash_we_n_o, .flash_dq_o,
        .flash_dq_oe_o, .flash_dq_i);
    flash_dev_model i_flash (.clk_i(mclk_i), .stall_i(stall), .addr_i(flash_addr_o),
        .ce_n_i(flash_ce_n_o), .oe_n_i(flash_oe_n_o), .we_n_i(flash_we_n_o),
        .dq_i(flash_dq_i), .dq_o(dev_dq));
    assign flash_dq_i = flash_dq_oe_o ? flash_dq_o : dev_dq;
    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done
    always @(negedge mclk_i) begin
        exp_type e;
        if (!sys_rst_i && rsp_valid_o === 1'b1) begin
            e = exp_q.pop_front();
            chk({7'h00, rsp_o.err}, {7'h00, e.e});
            if (e.c) chk(rsp_o.data, e.d);
            rsp_cnt++;
        end
    end
    // One command at a time; the next waits for the previous answer
    task automatic do_cmd(input op_type op, input logic [15:0] a, input logic [7:0] d,
                          input logic [7:0] ed, input logic ee, input logic ec);
        int n;
        int r;
        r = rsp_cnt;
        n = 0;
        exp_q.push_back('{d: ed, e: ee, c: ec});
        @(posedge mclk_i);
        cmd_valid_i <= 1'b1;
        cmd_i <= '{op: op, addr: a, data: d};
        do begin
            @(negedge mclk_i);
            n++;
        end while (cmd_ready_o !== 1'b1 && n < 5000);
        @(posedge mclk_i);
        cmd_valid_i <= 1'b0;
        while (rsp_cnt == r && n < 20000) begin
            @(negedge mclk_i);
            n++;
        end
        if (n >= 20000) error_cnt++;
    endtask : do_cmd
    task automatic prog(input logic [15:0] a, input logic [7:0] d);
        logic bad;
        bad = |(d & ~sh[a]);
        do_cmd(OP_PROGRAM, a, d, d, bad, !bad);
        if (!bad) sh[a] = d;
    endtask : prog
    task automatic rd(input logic [15:0] a);
        do_cmd(OP_READ, a, 8'h00, sh[a], 1'b0, 1'b1);
    endtask : rd
    task automatic fin(input string s);
        tno++;
        $display("Test %0d done: %s", tno, s);
    endtask : fin
    initial begin
        repeat (30000) @(posedge mclk_i);
        error_cnt++;
        test_done();
    end
    initial begin
        logic [15:0] a;
        logic [7:0]  d;
        seed = 3;
        error_cnt = 0;
        checked = 0;
        rsp_cnt = 0;
        tno = 0;
        sys_rst_i = 1'b1;
        cmd_valid_i = 1'b0;
        cmd_i = '0;
        stall = 1'b0;
        foreach (sh[i]) sh[i] = 8'hff;
        repeat (5) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        a = 16'h0200 | 16'($random(seed) & 16'h01ff);
        d = 8'($random(seed)) & 8'h7f;
        rd(a);
        prog(a, d);
        rd(a);
        prog(a, 8'h80);
        fin("program and refusal");
        do_cmd(OP_READ_RESET, 16'($random(seed)), CODE_READ, 8'h00, 1'b0, 1'b0);
        do_cmd(OP_SECTOR_ERASE, a, 8'h00, 8'hff, 1'b0, 1'b1);
        for (int i = 0; i < 512; i++) sh[int'(a & 16'hfe00) + i] = 8'hff;
        rd(a);
        fin("sector erase");
        a = 16'he000 | 16'($random(seed) & 16'h1fff);
        prog(a, 8'h00);
        do_cmd(OP_CHIP_ERASE, 16'h5555, 8'h00, 8'hff, 1'b0, 1'b1);
        foreach (sh[i]) sh[i] = 8'hff;
        rd(a);
        fin("chip erase");
        for (int i = 0; i < 10; i++) begin
            a = 16'h0100 | 16'($random(seed) & 16'h0007);
            prog(a, 8'($random(seed)));
            rd(a);
        end
        fin("random program");
        stall <= 1'b1;
        do_cmd(OP_PROGRAM, 16'h0300, 8'h5a, 8'h00, 1'b1, 1'b0);
        sh[16'h0300] = 8'h5a;
        stall <= 1'b0;
        repeat (40) @(posedge mclk_i);
        rd(16'h0300);
        fin("time-out");
        test_done();
    end
endmodule : flash_host_ctrl_tb
`default_nettype wire
